// [dv/iopc_host_model.sv]
// Host model: serial config master for the pin register pair.
// Assumes sclk idles low and the device samples si on sclk rising.
`timescale 1ns/10ps
module iopc_host_model (
  input wire logic clk_in,
  output logic sclk_out,
  output logic csn_out,
  output logic si_out,
  input wire logic so_in
);
  // Slow serial clock so the device's pin filter sees every level
  localparam int HALF = 20;
  initial begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    si_out = 1'b0;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [23:0] sh;
    sh = {cmd, wd};
    rd = 16'h0000;
    @(posedge clk_in);
    #1 csn_out = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      si_out = sh[i];
      repeat (HALF) @(posedge clk_in);
      if (i < 16) rd = {rd[14:0], so_in};
      #1 sclk_out = 1'b1;
      repeat (HALF) @(posedge clk_in);
      #1 sclk_out = 1'b0;
    end
    repeat (HALF) @(posedge clk_in);
    #1 csn_out = 1'b1;
    // Released line must not keep showing the last bit
    si_out = ~si_out;
    repeat (HALF) @(posedge clk_in);
  endtask : xfer
endmodule : iopc_host_model

// [dv/tb_top.sv]
// Self-checking bench for the I/O pin configuration register pair.
// Assumes the host model is the only master of the serial config port.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
  import iopc_pkg::*;
  logic clk_in, srst_in, sclk, csn, si, so, nonempty, dec_en, match;
  logic bcn, fifo_p, thr_p, fd_p, cc_p;
  logic [7:0] rx_bytes;
  logic [31:0] fd_src, cc_src;
  logic [2:0] dbg;
  logic [15:0] rd, w0, w1, pan_id, exp_w;
  logic synth_up;
  logic [15:0] exp_q[$];
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'h251B4D22;
  iopc_host_model host_u (.clk_in(clk_in), .sclk_out(sclk), .csn_out(csn), .si_out(si),
    .so_in(so));
  iopc_io_pin_config_regs dut_u (.clk_in(clk_in), .srst_in(srst_in), .spi_sclk_in(sclk),
    .spi_csn_in(csn), .spi_si_in(si), .spi_so_out(so), .rx_fifo_bytes_in(rx_bytes),
    .rx_fifo_nonempty_in(nonempty), .frame_delim_src_in(fd_src),
    .clear_channel_src_in(cc_src), .addr_decode_en_in(dec_en),
    .beacon_pan_match_in(match), .beacon_accept_out(bcn), .debug_serial_source_out(dbg),
    .fifo_pin_out(fifo_p), .rx_threshold_flag_pin_out(thr_p),
    .frame_delim_pin_out(fd_p), .clear_channel_pin_out(cc_p));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Roughly 35k cycles are needed; the limit leaves margin
  initial begin
    repeat (90000) @(posedge clk_in);
    num_errors++;
    report_and_stop();
  end
  initial begin
    srst_in = 1'b1;
    rx_bytes = 8'h00;
    nonempty = 1'b0;
    dec_en = 1'b0;
    match = 1'b0;
    fd_src = '0;
    cc_src = '0;
    repeat (8) @(posedge clk_in);
    #1 srst_in = 1'b0;
    host_u.xfer({2'b01, OFS_IO_FIRST}, 16'h0000, rd);
    `CHK("first rst", IO_FIRST_RST, rd & IO_FIRST_MASK)
    host_u.xfer({2'b01, OFS_IO_SECOND}, 16'h0000, rd);
    `CHK("second rst", IO_SECOND_RST, rd & IO_SECOND_MASK)
    // The synthesizer is taken as running before any debug source is chosen
    synth_up = 1'b1;
    // Every debug source code, random polarities and selects
    for (int i = 0; i < 8; i++) begin
      pan_id = i[0] ? 16'hFFFF : 16'($random(seed));
      w0 = 16'($random(seed)) & IO_FIRST_MASK;
      w0[BIT_ACCEPT_BEACON] = (pan_id == 16'hFFFF);
      w1 = 16'($random(seed)) & 16'h03FF;
      w1 = w1 | (synth_up ? (16'(i) << DBG_LSB) : 16'h0000);
      host_u.xfer({2'b00, OFS_IO_FIRST}, w0, rd);
      exp_q.push_back(w0);
      host_u.xfer({2'b00, OFS_IO_SECOND}, w1, rd);
      exp_q.push_back(w1);
      host_u.xfer({2'b01, OFS_IO_FIRST}, 16'h0000, rd);
      exp_w = exp_q.pop_front();
      `CHK("first rd", exp_w, rd & IO_FIRST_MASK)
      host_u.xfer({2'b01, OFS_IO_SECOND}, 16'h0000, rd);
      exp_w = exp_q.pop_front();
      `CHK("second rd", exp_w, rd & IO_SECOND_MASK)
      @(posedge clk_in);
      // Byte count just below, at and above the threshold
      #1 rx_bytes = {1'b0, w0[6:0]} + 8'(i % 3) - 8'h01;
      nonempty = i[0];
      dec_en = i[1];
      match = i[2];
      fd_src = $random(seed);
      cc_src = $random(seed);
      repeat (12) @(posedge clk_in);
      `CHK("dbg src", w1[12:10], dbg)
      `CHK("beacon", !dec_en || w0[11] || match, bcn)
      `CHK("fifo pin", nonempty ^ w0[10], fifo_p)
      `CHK("thr pin", (int'(rx_bytes) >= int'(w0[6:0])) ^ w0[9], thr_p)
      `CHK("fd pin", fd_src[w1[9:5]] ^ w0[8], fd_p)
      `CHK("cc pin", cc_src[w1[4:0]] ^ w0[7], cc_p)
    end
    report_and_stop();
  end
endmodule : tb_top

// [rtl/iopc_io_pin_config_regs.sv]
// I/O pin configuration register pair with its serial config port and pin logic.
// Assumes serial clock idles low, data sampled on its rising edge, csn low frames one access.
//
// Contract
// - With accept-all set, every beacon is accepted; with it clear, only beacons whose network id matches.
// - Every beacon is accepted while address recognition is disabled, accept-all or not.
// - Bit 10 inverts the FIFO indicator pin: 0 active high, 1 active low.
// - Bit 9 inverts the FIFO threshold indicator pin: 0 active high, 1 active low.
// - Bit 8 inverts the frame delimiter pin: 0 active high, 1 active low.
// - Bit 7 inverts the clear channel pin: 0 active high, 1 active low.
// - Bits 6 to 0, reset 64, give the receive byte count at which the threshold flag goes active.
// - Bits 12 to 10 of the second register select the debug serial source.
// - Bits 9 to 5 of the second register pick the frame delimiter pin source, reset zero.
// - Bits 4 to 0 of the second register pick the clear channel pin source, reset zero.
`timescale 1ns/10ps
module iopc_io_pin_config_regs
  import iopc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic spi_sclk_in,
  input wire logic spi_csn_in,
  input wire logic spi_si_in,
  output logic spi_so_out,
  input wire logic [7:0] rx_fifo_bytes_in,
  input wire logic rx_fifo_nonempty_in,
  input wire logic [31:0] frame_delim_src_in,
  input wire logic [31:0] clear_channel_src_in,
  input wire logic addr_decode_en_in,
  input wire logic beacon_pan_match_in,
  output logic beacon_accept_out,
  output logic [2:0] debug_serial_source_out,
  output logic fifo_pin_out,
  output logic rx_threshold_flag_pin_out,
  output logic frame_delim_pin_out,
  output logic clear_channel_pin_out
);

  typedef struct packed {
    iopc_state_t st;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [15:0] tx;
    logic [5:0] addr;
    logic wr_ok;
    logic so;
    logic sclk_q;
    logic bcn;
    logic [2:0] dbg;
    logic [15:0] io_first;
    logic [15:0] io_second;
  } iopc_regs_t;

  // Idle serial port, registers at their defaults
  localparam iopc_regs_t REGS_RST = '{
    st: ST_IDLE,
    cnt: 5'h00,
    sh: 16'h0000,
    tx: 16'h0000,
    addr: 6'h00,
    wr_ok: 1'b0,
    so: 1'b0,
    sclk_q: 1'b0,
    bcn: 1'b0,
    dbg: DBG_OFF,
    io_first: IO_FIRST_RST,
    io_second: IO_SECOND_RST
  };

  iopc_regs_t r_ff;
  iopc_regs_t nxt_r;

  logic [2:0] pins_sync;
  logic sclk_s;
  logic csn_s;
  logic si_s;
  logic sclk_rise;
  logic sclk_fall;
  logic wr_first;
  logic wr_second;
  logic [15:0] wr_word;
  logic thr_active;
  logic fd_active;
  logic cc_active;
  logic [3:0] pin_active;
  logic [3:0] pin_invert;
  logic [3:0] pins;

  // Source pick is shared by both pin multiplexers
  function automatic logic pick_src(input logic [31:0] src, input logic [4:0] sel);
    pick_src = src[sel];
  endfunction : pick_src

  // Unmapped offsets read as zero
  function automatic logic [15:0] read_word(input logic [5:0] addr, input logic [15:0] first,
                                            input logic [15:0] second);
    read_word = 16'h0000;
    if (addr == OFS_IO_FIRST) begin
      read_word = first;
    end else if (addr == OFS_IO_SECOND) begin
      read_word = second;
    end
  endfunction : read_word

  iopc_pin_sync #(
    .W(3),
    .RST_VAL(3'h2)
  ) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .raw_in({spi_si_in, spi_csn_in, spi_sclk_in}),
    .level_out(pins_sync)
  );

  assign sclk_s = pins_sync[0];
  assign csn_s = pins_sync[1];
  assign si_s = pins_sync[2];
  assign sclk_rise = sclk_s & ~r_ff.sclk_q;
  assign sclk_fall = ~sclk_s & r_ff.sclk_q;

  always_comb begin
    logic [15:0] nsh;
    logic last_data;
    nsh = {r_ff.sh[14:0], si_s};
    last_data = 1'b0;
    nxt_r = r_ff;
    nxt_r.sclk_q = sclk_s;
    wr_first = 1'b0;
    wr_second = 1'b0;
    wr_word = 16'h0000;
    if (csn_s) begin
      nxt_r.st = ST_IDLE;
      nxt_r.so = 1'b0;
    end else begin
      case (r_ff.st)
        ST_IDLE: begin
          nxt_r.st = ST_CMD;
          nxt_r.cnt = 5'h00;
          nxt_r.so = 1'b0;
          nxt_r.wr_ok = 1'b0;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            nxt_r.sh = nsh;
            nxt_r.cnt = r_ff.cnt + 5'h01;
            if (r_ff.cnt == CMD_BITS - 5'h01) begin
              // Memory-space accesses are not ours: neither read data nor writes
              nxt_r.wr_ok = ~nsh[CMD_READ_BIT] & ~nsh[CMD_RAM_BIT];
              // The address is kept aside because the data bits push it out of sh
              nxt_r.addr = nsh[ADDR_W-1:0];
              nxt_r.tx = nsh[CMD_RAM_BIT] ? 16'h0000
                       : read_word(nsh[ADDR_W-1:0], r_ff.io_first, r_ff.io_second);
              nxt_r.cnt = 5'h00;
              nxt_r.st = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // Read data moves on the falling edge so it is settled at the host's rising edge
          if (sclk_fall) begin
            nxt_r.so = r_ff.tx[15];
            nxt_r.tx = {r_ff.tx[14:0], 1'b0};
          end
          if (sclk_rise) begin
            nxt_r.sh = nsh;
            nxt_r.cnt = r_ff.cnt + 5'h01;
            if (r_ff.cnt == DATA_BITS - 5'h01) begin
              nxt_r.st = ST_DONE;
              last_data = 1'b1;
            end
          end
        end
        ST_DONE: begin
          nxt_r.so = 1'b0;
        end
        default: begin
          nxt_r.st = ST_IDLE;
        end
      endcase
    end
    // A frame cut before its last bit writes nothing
    if (last_data && r_ff.wr_ok) begin
      wr_word = nsh;
      wr_first = (r_ff.addr == OFS_IO_FIRST);
      wr_second = (r_ff.addr == OFS_IO_SECOND);
    end
    // Reserved bits are dropped so they always read back as zero
    if (wr_first) begin
      nxt_r.io_first = wr_word & IO_FIRST_MASK;
    end
    if (wr_second) begin
      nxt_r.io_second = wr_word & IO_SECOND_MASK;
    end
    nxt_r.bcn = ~addr_decode_en_in | r_ff.io_first[BIT_ACCEPT_BEACON] | beacon_pan_match_in;
    nxt_r.dbg = r_ff.io_second[DBG_MSB:DBG_LSB];
  end

  assign thr_active = rx_fifo_bytes_in >= {1'b0, r_ff.io_first[THR_MSB:THR_LSB]};
  assign fd_active = pick_src(frame_delim_src_in, r_ff.io_second[FD_SEL_MSB:FD_SEL_LSB]);
  assign cc_active = pick_src(clear_channel_src_in, r_ff.io_second[CC_SEL_MSB:CC_SEL_LSB]);
  assign pin_active = {rx_fifo_nonempty_in, thr_active, fd_active, cc_active};
  assign pin_invert = {r_ff.io_first[BIT_FIFO_INV], r_ff.io_first[BIT_THR_INV],
                       r_ff.io_first[BIT_FD_INV], r_ff.io_first[BIT_CC_INV]};

  iopc_pin_drive u_drive (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .active_in(pin_active),
    .invert_in(pin_invert),
    .pin_out(pins)
  );

  assign fifo_pin_out = pins[3];
  assign rx_threshold_flag_pin_out = pins[2];
  assign frame_delim_pin_out = pins[1];
  assign clear_channel_pin_out = pins[0];

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_ff <= REGS_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign spi_so_out = r_ff.so;
  assign beacon_accept_out = r_ff.bcn;
  assign debug_serial_source_out = r_ff.dbg;

  bcn_ignored_a: assert property (@(posedge clk_in) disable iff (srst_in)
    !addr_decode_en_in |=> beacon_accept_out)
    else $error("beacon rejected while address decode is off");

  accept_all_beacons_all_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (addr_decode_en_in && r_ff.io_first[BIT_ACCEPT_BEACON]) |=> beacon_accept_out)
    else $error("beacon rejected with accept-all set");

  bcn_match_only_a: assert property (@(posedge clk_in) disable iff (srst_in)
    (addr_decode_en_in && !r_ff.io_first[BIT_ACCEPT_BEACON])
    |=> beacon_accept_out == $past(beacon_pan_match_in))
    else $error("beacon acceptance does not follow the network id match");

  dbg_source_a: assert property (@(posedge clk_in) disable iff (srst_in)
    1'b1 |=> debug_serial_source_out == $past(r_ff.io_second[DBG_MSB:DBG_LSB]))
    else $error("debug source output differs from its field");

  thr_reset_a: assert property (@(posedge clk_in)
    srst_in |=> r_ff.io_first[THR_MSB:THR_LSB] == THR_RST)
    else $error("byte threshold not at its reset value");

  write_first_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_first |=> r_ff.io_first == $past(wr_word & IO_FIRST_MASK))
    else $error("write to first register did not land");

  write_second_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_second |=> r_ff.io_second == $past(wr_word & IO_SECOND_MASK))
    else $error("write to second register did not land");

  fifo_pin_a: assert property (@(posedge clk_in) disable iff (srst_in)
    1'b1 |=> fifo_pin_out == $past(rx_fifo_nonempty_in ^ r_ff.io_first[BIT_FIFO_INV]))
    else $error("fifo pin level wrong");

  thr_pin_a: assert property (@(posedge clk_in) disable iff (srst_in)
    1'b1 |=> rx_threshold_flag_pin_out == $past(thr_active ^ r_ff.io_first[BIT_THR_INV]))
    else $error("threshold pin level wrong");

  fd_pin_a: assert property (@(posedge clk_in) disable iff (srst_in)
    1'b1 |=> frame_delim_pin_out == $past(fd_active ^ r_ff.io_first[BIT_FD_INV]))
    else $error("frame delimiter pin level wrong");

  cc_pin_a: assert property (@(posedge clk_in) disable iff (srst_in)
    1'b1 |=> clear_channel_pin_out == $past(cc_active ^ r_ff.io_first[BIT_CC_INV]))
    else $error("clear channel pin level wrong");

  reserved_zero_a: assert property (@(posedge clk_in) disable iff (srst_in)
    ((r_ff.io_first & ~IO_FIRST_MASK) == 16'h0000)
    && ((r_ff.io_second & ~IO_SECOND_MASK) == 16'h0000))
    else $error("reserved register bits hold a one");

  so_idle_a: assert property (@(posedge clk_in) disable iff (srst_in)
    csn_s |=> !spi_so_out)
    else $error("serial output driven outside a frame");

  cov_write_first: cover property (@(posedge clk_in) disable iff (srst_in) wr_first);

  cov_write_second: cover property (@(posedge clk_in) disable iff (srst_in) wr_second);

  cov_thr_inverted: cover property (@(posedge clk_in) disable iff (srst_in)
    thr_active && r_ff.io_first[BIT_THR_INV]);

  cov_bcn_filtered: cover property (@(posedge clk_in) disable iff (srst_in)
    addr_decode_en_in && !beacon_pan_match_in && !r_ff.io_first[BIT_ACCEPT_BEACON]);

endmodule : iopc_io_pin_config_regs

// [rtl/iopc_pin_drive.sv]
// Output stage for the four status pins: polarity inversion then a register.
// Assumes active-high internal indicators from the same clock domain.
`timescale 1ns/10ps
module iopc_pin_drive (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [3:0] active_in,
  input wire logic [3:0] invert_in,
  output logic [3:0] pin_out
);

  typedef struct packed {
    logic [3:0] pin;
  } iopc_drive_t;

  iopc_drive_t r_ff;
  iopc_drive_t nxt_r;

  // Inversion sits before the register so a polarity write shows on the next edge
  always_comb begin
    nxt_r.pin = active_in ^ invert_in;
  end

  // Reset value matches an idle, non-inverted pin
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pin_out = r_ff.pin;

endmodule : iopc_pin_drive

// [rtl/iopc_pin_sync.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pins; the filtered level only moves when stages two and three agree.
`timescale 1ns/10ps
module iopc_pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [W-1:0] raw_in,
  output logic [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } iopc_sync_t;

  iopc_sync_t r_ff;
  iopc_sync_t nxt_r;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = raw_in;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (r_ff.s2[i] == r_ff.s3[i]) begin
        nxt_r.lvl[i] = r_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_ff <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign level_out = r_ff.lvl;

endmodule : iopc_pin_sync

// [rtl/iopc_pkg.sv]
// Constants for the I/O pin configuration register pair.
// Assumes a 6-bit register address and 16-bit registers reached over the serial config port.
package iopc_pkg;

  localparam int ADDR_W = 6;
  localparam int REG_W = 16;
  localparam int SRC_N = 32;

  // Register offsets
  localparam logic [5:0] OFS_IO_FIRST = 6'h1C;
  localparam logic [5:0] OFS_IO_SECOND = 6'h1D;

  // First register fields
  localparam int BIT_ACCEPT_BEACON = 11;
  localparam int BIT_FIFO_INV = 10;
  localparam int BIT_THR_INV = 9;
  localparam int BIT_FD_INV = 8;
  localparam int BIT_CC_INV = 7;
  localparam int THR_MSB = 6;
  localparam int THR_LSB = 0;
  localparam logic [6:0] THR_RST = 7'h40;
  localparam logic [15:0] IO_FIRST_RST = 16'h0040;
  localparam logic [15:0] IO_FIRST_MASK = 16'h0FFF;

  // Second register fields
  localparam int DBG_MSB = 12;
  localparam int DBG_LSB = 10;
  localparam int FD_SEL_MSB = 9;
  localparam int FD_SEL_LSB = 5;
  localparam int CC_SEL_MSB = 4;
  localparam int CC_SEL_LSB = 0;
  localparam logic [15:0] IO_SECOND_RST = 16'h0000;
  localparam logic [15:0] IO_SECOND_MASK = 16'h1FFF;

  // Debug serial source codes; 4 and 5 are reserved
  localparam logic [2:0] DBG_OFF = 3'h0;
  localparam logic [2:0] DBG_GAIN_STATUS = 3'h1;
  localparam logic [2:0] DBG_ADC_OUT = 3'h2;
  localparam logic [2:0] DBG_FILTERED_IQ = 3'h3;
  localparam logic [2:0] DBG_ADC_IN = 3'h6;
  localparam logic [2:0] DBG_DAC_IN = 3'h7;

  // Serial frame: command byte then one 16-bit word, msb first
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam int CMD_RAM_BIT = 7;
  localparam int CMD_READ_BIT = 6;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } iopc_state_t;

endpackage : iopc_pkg
